// >>> rtl/iem_pkg.sv
// Constants, field layout and encodings for the input event action mapper.
// Assumes a 25 MHz system clock and a classic Wishbone register port.
package iem_pkg;
   // Timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned TICK_PERIOD_S = 1;
   localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_PERIOD_S;
   localparam logic [5:0] MAX_MIN = 6'h3B;
   localparam logic [5:0] MAX_SEC = 6'h3B;
   localparam logic [6:0] MAX_PCT = 7'h64;
   localparam int unsigned TMR_W = 12;

   // Register byte offsets
   localparam logic [7:0] OFS_BTN_CFG = 8'h00;
   localparam logic [7:0] OFS_SEQ_CFG = 8'h04;
   localparam logic [7:0] OFS_OCC_CFG = 8'h08;
   localparam logic [7:0] OFS_VAC_DLY = 8'h0C;
   localparam logic [7:0] OFS_OCC_HLD = 8'h10;
   localparam logic [7:0] OFS_VAC_HLD = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_SRC_SEL = 8'h1C;

   // Button configuration fields
   localparam int unsigned BTN_RLY_DBL = 0;
   localparam int unsigned BTN_SEQ_SHT = 2;
   localparam int unsigned BTN_SEQ_DBL = 4;
   localparam int unsigned BTN_CMB_SHT = 6;
   localparam int unsigned BTN_CMB_DBL = 7;
   localparam int unsigned BTN_DCL_SHT = 8;
   localparam int unsigned BTN_DCL_DBL = 10;
   // Sequence configuration fields
   localparam int unsigned SEQ_LOOPS = 0;
   localparam int unsigned SEQ_NONSTOP = 8;
   localparam int unsigned SEQ_FINISH = 9;
   // Occupancy configuration fields
   localparam int unsigned OCC_LMP_ACT = 0;
   localparam int unsigned VAC_LMP_ACT = 4;
   localparam int unsigned OCC_SCENE = 8;
   localparam int unsigned OCC_LEVEL = 16;
   localparam int unsigned OCC_RLY_ACT = 24;
   localparam int unsigned OCC_REVERT = 26;
   localparam int unsigned VAC_RLY_ACT = 28;
   localparam int unsigned VAC_REVERT = 30;
   // Minute/second timer fields
   localparam int unsigned TM_SEC = 0;
   localparam int unsigned TM_MIN = 8;

   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RST_SEQ_CFG = 32'h0000_0001;

   typedef enum logic [1:0] {RLY_NONE, RLY_ON, RLY_OFF, RLY_TOGGLE} iem_rly_act_t;
   typedef enum logic [1:0] {SQA_NONE, SQA_START, SQA_STOP, SQA_TOGGLE} iem_seq_act_t;
   typedef enum logic [1:0] {DCA_NONE, DCA_START, DCA_STOP, DCA_SPARE} iem_dcl_act_t;
   typedef enum logic [2:0] {LMA_NONE, LMA_OFF, LMA_LEVEL, LMA_LAST, LMA_SCENE} iem_lmp_act_t;
   typedef enum logic [1:0] {OP_OFF, OP_LEVEL, OP_LAST, OP_SCENE} iem_lamp_op_t;
endpackage

// >>> rtl/iem_mapper.sv
// Input event action mapper: turns classified button and presence events into
// relay, sequence, combination, daylight-cycle and lamp commands.
// Assumes events are same-clock single-cycle pulses and a Wishbone master.
//
// Overview of operation
// - Double push per setting: nothing, relay on, relay off, or relay toggle.
// - Short push per setting: ignore, start, stop, or toggle the sequence.
// - Double push per own setting: ignore, start, stop, or toggle the sequence.
// - Non-stop sequence repeats forever; else runs 1 to 255 loops then halts.
// - Immediate stop policy aborts the running sequence at once.
// - Finish-cycle policy lets the current loop end before halting.
// - Short and double push each either ignored or start combination output.
// - Short and double push each ignore, start or stop daylight-cycle lighting.
// - Occupancy off action switches lamps off; disabled action issues nothing.
// - Occupancy go-to-level commands configured brightness 0 to 100 percent.
// - Occupancy last-level action restores the lamps' previous brightness.
// - Occupancy scene action recalls configured scene 0 to 15.
// - Vacancy per setting: nothing, off, go to level, or last level.
// - Vacancy off happens only after configured delay up to 59:59.
// - Occupancy per setting leaves relay, switches it on, or off.
// - With revert, relay prior state returns after hold time up to 59:59.
// - Without revert, relay keeps the event-set state indefinitely.
// - Vacancy relay action with own setting, revert option and hold time.
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
module iem_mapper #(
   parameter int unsigned SEC_CYCLES = iem_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Classified input events
   input wire logic short_push_i,
   input wire logic double_push_i,
   input wire logic occupied_i,
   input wire logic vacant_i,
   input wire logic [7:0] src_i,
   // Sequence engine
   input wire logic seq_loop_done_i,
   output logic seq_run_o,
   output logic seq_start_o,
   output logic seq_abort_o,
   // Relay, combination output, daylight-cycle lighting
   output logic relay_o,
   output logic comb_start_o,
   output logic daylight_cycle_lighting_run_o,
   output logic daylight_cycle_lighting_start_o,
   output logic daylight_cycle_lighting_stop_o,
   // Lamp command issuer
   output logic lamp_cmd_valid_o,
   output iem_pkg::iem_lamp_op_t lamp_op_o,
   output logic [7:0] lamp_arg_o
);
   import iem_pkg::*;

   localparam int unsigned PRE_W = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SEC_CYCLES - 1);

   generate
      if (SEC_CYCLES < 1) begin : g_bad_tick
         $error("SEC_CYCLES must be at least 1");
      end
   endgenerate

   // Minutes and seconds field to whole seconds, fields clamped to 59
   function automatic logic [TMR_W-1:0] to_secs(input logic [31:0] r);
      logic [5:0] m;
      logic [5:0] s;
      m = (r[TM_MIN +: 6] > MAX_MIN) ? MAX_MIN : r[TM_MIN +: 6];
      s = (r[TM_SEC +: 6] > MAX_SEC) ? MAX_SEC : r[TM_SEC +: 6];
      to_secs = TMR_W'(m) * TMR_W'(60) + TMR_W'(s);
   endfunction

   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   logic [31:0] btn_cfg_r;
   logic [31:0] seq_cfg_r;
   logic [31:0] occ_cfg_r;
   logic [31:0] vac_dly_r;
   logic [31:0] occ_hld_r;
   logic [31:0] vac_hld_r;
   logic [31:0] src_sel_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic [31:0] status;
   logic [31:0] rd_mux;
   logic wr_en;

   logic relay_r;
   logic seq_run_r;
   logic stop_pend_r;
   logic [7:0] loop_cnt_r;
   logic seq_start_r;
   logic seq_abort_r;
   logic comb_r;
   logic dcl_run_r;
   logic dcl_start_r;
   logic dcl_stop_r;
   logic cmd_valid_r;
   iem_lamp_op_t cmd_op_r;
   logic [7:0] cmd_arg_r;
   logic [PRE_W-1:0] pre_r;
   logic tick;
   logic [TMR_W-1:0] dly_r;
   logic dly_act_r;
   logic [TMR_W-1:0] hld_r;
   logic hld_act_r;
   logic hld_prior_r;

   // Wishbone slave
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         btn_cfg_r <= RST_ZERO;
         seq_cfg_r <= RST_SEQ_CFG;
         occ_cfg_r <= RST_ZERO;
         vac_dly_r <= RST_ZERO;
         occ_hld_r <= RST_ZERO;
         vac_hld_r <= RST_ZERO;
         src_sel_r <= RST_ZERO;
      end else if (wr_en) begin
         unique case ({wb_adr_i[7:2], 2'b00})
            OFS_BTN_CFG: btn_cfg_r <= merge(btn_cfg_r, wb_dat_i, wb_sel_i);
            OFS_SEQ_CFG: seq_cfg_r <= merge(seq_cfg_r, wb_dat_i, wb_sel_i);
            OFS_OCC_CFG: occ_cfg_r <= merge(occ_cfg_r, wb_dat_i, wb_sel_i);
            OFS_VAC_DLY: vac_dly_r <= merge(vac_dly_r, wb_dat_i, wb_sel_i);
            OFS_OCC_HLD: occ_hld_r <= merge(occ_hld_r, wb_dat_i, wb_sel_i);
            OFS_VAC_HLD: vac_hld_r <= merge(vac_hld_r, wb_dat_i, wb_sel_i);
            OFS_SRC_SEL: src_sel_r <= merge(src_sel_r, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   always_comb begin
      status = RST_ZERO;
      status[0] = relay_r;
      status[1] = seq_run_r;
      status[2] = dcl_run_r;
      status[3] = stop_pend_r;
      status[15:8] = loop_cnt_r;
      status[16] = dly_act_r;
      status[17] = hld_act_r;
      unique case ({wb_adr_i[7:2], 2'b00})
         OFS_BTN_CFG: rd_mux = btn_cfg_r;
         OFS_SEQ_CFG: rd_mux = seq_cfg_r;
         OFS_OCC_CFG: rd_mux = occ_cfg_r;
         OFS_VAC_DLY: rd_mux = vac_dly_r;
         OFS_OCC_HLD: rd_mux = occ_hld_r;
         OFS_VAC_HLD: rd_mux = vac_hld_r;
         OFS_STATUS: rd_mux = status;
         OFS_SRC_SEL: rd_mux = src_sel_r;
         default: rd_mux = RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_r <= RST_ZERO;
      end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
         rdat_r <= rd_mux;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // Event decode
   logic hit;
   logic ev_sht;
   logic ev_dbl;
   logic ev_occ;
   logic ev_vac;
   iem_seq_act_t seq_act;
   iem_dcl_act_t dcl_sht;
   iem_dcl_act_t dcl_dbl;
   iem_rly_act_t rly_dbl;
   iem_rly_act_t rly_occ;
   iem_rly_act_t rly_vac;
   iem_lmp_act_t lmp_occ;
   iem_lmp_act_t lmp_vac;
   logic [6:0] level;

   assign hit = (src_i == src_sel_r[7:0]);
   assign ev_sht = short_push_i & hit;
   assign ev_dbl = double_push_i & hit;
   assign ev_occ = occupied_i & hit;
   assign ev_vac = vacant_i & hit;

   // Short push with a non-ignore setting takes precedence over double push in the same cycle
   always_comb begin
      if (ev_sht && btn_cfg_r[BTN_SEQ_SHT +: 2] != 2'h0) begin
         seq_act = iem_seq_act_t'(btn_cfg_r[BTN_SEQ_SHT +: 2]);
      end else if (ev_dbl) begin
         seq_act = iem_seq_act_t'(btn_cfg_r[BTN_SEQ_DBL +: 2]);
      end else begin
         seq_act = SQA_NONE;
      end
   end

   assign dcl_sht = ev_sht ? iem_dcl_act_t'(btn_cfg_r[BTN_DCL_SHT +: 2]) : DCA_NONE;
   assign dcl_dbl = ev_dbl ? iem_dcl_act_t'(btn_cfg_r[BTN_DCL_DBL +: 2]) : DCA_NONE;
   assign rly_dbl = ev_dbl ? iem_rly_act_t'(btn_cfg_r[BTN_RLY_DBL +: 2]) : RLY_NONE;
   assign rly_occ = ev_occ ? iem_rly_act_t'(occ_cfg_r[OCC_RLY_ACT +: 2]) : RLY_NONE;
   assign rly_vac = ev_vac ? iem_rly_act_t'(occ_cfg_r[VAC_RLY_ACT +: 2]) : RLY_NONE;
   assign lmp_occ = ev_occ ? iem_lmp_act_t'(occ_cfg_r[OCC_LMP_ACT +: 3]) : LMA_NONE;
   assign lmp_vac = ev_vac ? iem_lmp_act_t'(occ_cfg_r[VAC_LMP_ACT +: 3]) : LMA_NONE;
   assign level = (occ_cfg_r[OCC_LEVEL +: 7] > MAX_PCT) ? MAX_PCT : occ_cfg_r[OCC_LEVEL +: 7];

   // Sequence control
   logic seq_go;
   logic seq_halt;
   logic last_loop;

   always_comb begin
      seq_go = 1'b0;
      seq_halt = 1'b0;
      unique case (seq_act)
         SQA_START: seq_go = 1'b1;
         SQA_STOP: seq_halt = 1'b1;
         SQA_TOGGLE: begin
            seq_go = ~seq_run_r;
            seq_halt = seq_run_r;
         end
         default: ;
      endcase
   end

   // Loop count of zero behaves as one
   assign last_loop = ~seq_cfg_r[SEQ_NONSTOP] &
                      ((loop_cnt_r + 8'h01) >= seq_cfg_r[SEQ_LOOPS +: 8]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_run_r <= 1'b0;
         stop_pend_r <= 1'b0;
         loop_cnt_r <= 8'h00;
         seq_start_r <= 1'b0;
         seq_abort_r <= 1'b0;
      end else begin
         seq_start_r <= seq_go;
         seq_abort_r <= 1'b0;
         if (seq_go) begin
            seq_run_r <= 1'b1;
            stop_pend_r <= 1'b0;
            loop_cnt_r <= 8'h00;
         end else if (seq_halt && seq_run_r && !seq_cfg_r[SEQ_FINISH]) begin
            seq_run_r <= 1'b0;
            stop_pend_r <= 1'b0;
            seq_abort_r <= 1'b1;
         end else begin
            if (seq_halt && seq_run_r) begin
               stop_pend_r <= 1'b1;
            end
            if (seq_loop_done_i && seq_run_r) begin
               loop_cnt_r <= loop_cnt_r + 8'h01;
               if (stop_pend_r || seq_halt || last_loop) begin
                  seq_run_r <= 1'b0;
                  stop_pend_r <= 1'b0;
               end
            end
         end
      end
   end

   assign seq_run_o = seq_run_r;
   assign seq_start_o = seq_start_r;
   assign seq_abort_o = seq_abort_r;

   // Combination and daylight-cycle lighting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comb_r <= 1'b0;
         dcl_run_r <= 1'b0;
         dcl_start_r <= 1'b0;
         dcl_stop_r <= 1'b0;
      end else begin
         comb_r <= (ev_sht & btn_cfg_r[BTN_CMB_SHT]) | (ev_dbl & btn_cfg_r[BTN_CMB_DBL]);
         dcl_start_r <= (dcl_sht == DCA_START) | (dcl_dbl == DCA_START);
         dcl_stop_r <= (dcl_sht == DCA_STOP) | (dcl_dbl == DCA_STOP);
         if (dcl_sht == DCA_START || dcl_dbl == DCA_START) begin
            dcl_run_r <= 1'b1;
         end else if (dcl_sht == DCA_STOP || dcl_dbl == DCA_STOP) begin
            dcl_run_r <= 1'b0;
         end
      end
   end

   assign comb_start_o = comb_r;
   assign daylight_cycle_lighting_run_o = dcl_run_r;
   assign daylight_cycle_lighting_start_o = dcl_start_r;
   assign daylight_cycle_lighting_stop_o = dcl_stop_r;

   // One-second tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_r <= '0;
      end else if (pre_r == PRE_LAST) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + PRE_W'(1);
      end
   end

   assign tick = (pre_r == PRE_LAST);

   // Lamp commands and vacancy delay
   logic dly_load;
   logic dly_fire;

   assign dly_load = (lmp_vac == LMA_OFF) && (to_secs(vac_dly_r) != '0);
   assign dly_fire = dly_act_r && tick && (dly_r == TMR_W'(1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dly_r <= '0;
         dly_act_r <= 1'b0;
      end else if (ev_occ) begin
         dly_act_r <= 1'b0;
      end else if (dly_load) begin
         dly_r <= to_secs(vac_dly_r);
         dly_act_r <= 1'b1;
      end else if (ev_vac) begin
         dly_act_r <= 1'b0;
      end else if (dly_act_r && tick) begin
         dly_r <= dly_r - TMR_W'(1);
         dly_act_r <= ~dly_fire;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_valid_r <= 1'b0;
         cmd_op_r <= OP_OFF;
         cmd_arg_r <= 8'h00;
      end else begin
         cmd_valid_r <= 1'b0;
         if (ev_occ) begin
            unique case (lmp_occ)
               LMA_OFF: begin
                  cmd_valid_r <= 1'b1;
                  cmd_op_r <= OP_OFF;
               end
               LMA_LEVEL: begin
                  cmd_valid_r <= 1'b1;
                  cmd_op_r <= OP_LEVEL;
                  cmd_arg_r <= {1'b0, level};
               end
               LMA_LAST: begin
                  cmd_valid_r <= 1'b1;
                  cmd_op_r <= OP_LAST;
               end
               LMA_SCENE: begin
                  cmd_valid_r <= 1'b1;
                  cmd_op_r <= OP_SCENE;
                  cmd_arg_r <= {4'h0, occ_cfg_r[OCC_SCENE +: 4]};
               end
               default: ;
            endcase
         end else if (ev_vac) begin
            unique case (lmp_vac)
               LMA_OFF: begin
                  cmd_valid_r <= ~dly_load;
                  cmd_op_r <= OP_OFF;
               end
               LMA_LEVEL: begin
                  cmd_valid_r <= 1'b1;
                  cmd_op_r <= OP_LEVEL;
                  cmd_arg_r <= {1'b0, level};
               end
               LMA_LAST: begin
                  cmd_valid_r <= 1'b1;
                  cmd_op_r <= OP_LAST;
               end
               default: ;
            endcase
         end else if (dly_fire) begin
            cmd_valid_r <= 1'b1;
            cmd_op_r <= OP_OFF;
         end
      end
   end

   assign lamp_cmd_valid_o = cmd_valid_r;
   assign lamp_op_o = cmd_op_r;
   assign lamp_arg_o = cmd_arg_r;

   // Relay and hold timer
   logic sns_set;
   logic sns_val;
   logic sns_rev;
   logic [TMR_W-1:0] hld_val;
   logic hld_fire;

   always_comb begin
      sns_set = 1'b0;
      sns_val = 1'b0;
      sns_rev = 1'b0;
      hld_val = '0;
      if (rly_occ == RLY_ON || rly_occ == RLY_OFF) begin
         sns_set = 1'b1;
         sns_val = (rly_occ == RLY_ON);
         sns_rev = occ_cfg_r[OCC_REVERT];
         hld_val = to_secs(occ_hld_r);
      end else if (rly_vac == RLY_ON || rly_vac == RLY_OFF) begin
         sns_set = 1'b1;
         sns_val = (rly_vac == RLY_ON);
         sns_rev = occ_cfg_r[VAC_REVERT];
         hld_val = to_secs(vac_hld_r);
      end
   end

   assign hld_fire = hld_act_r && tick && (hld_r == TMR_W'(1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         relay_r <= 1'b0;
         hld_r <= '0;
         hld_act_r <= 1'b0;
         hld_prior_r <= 1'b0;
      end else if (rly_dbl != RLY_NONE) begin
         // Manual relay action cancels any pending restore
         hld_act_r <= 1'b0;
         unique case (rly_dbl)
            RLY_ON: relay_r <= 1'b1;
            RLY_OFF: relay_r <= 1'b0;
            RLY_TOGGLE: relay_r <= ~relay_r;
            default: ;
         endcase
      end else if (sns_set) begin
         relay_r <= sns_val;
         if (sns_rev && hld_val != '0) begin
            hld_r <= hld_val;
            hld_act_r <= 1'b1;
            if (!hld_act_r) begin
               hld_prior_r <= relay_r;
            end
         end else begin
            hld_act_r <= 1'b0;
            if (sns_rev && hld_act_r) begin
               relay_r <= hld_prior_r;
            end else if (sns_rev) begin
               relay_r <= relay_r;
            end
         end
      end else if (hld_act_r && tick) begin
         hld_r <= hld_r - TMR_W'(1);
         if (hld_fire) begin
            hld_act_r <= 1'b0;
            relay_r <= hld_prior_r;
         end
      end
   end

   assign relay_o = relay_r;
endmodule

// >>> test/iem_mapper_properties.sv
// Concurrent checks on the ports of the input event action mapper.
// Assumes one clock, synchronous active-high reset, bound onto every instance.
`timescale 1ns/10ps
module iem_mapper_checker
   import iem_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = iem_pkg::SEC_CYCLES
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Events and outputs
   input wire logic short_push_i,
   input wire logic double_push_i,
   input wire logic occupied_i,
   input wire logic vacant_i,
   input wire logic seq_loop_done_i,
   input wire logic seq_run_o,
   input wire logic seq_start_o,
   input wire logic seq_abort_o,
   input wire logic comb_start_o,
   input wire logic daylight_cycle_lighting_run_o,
   input wire logic daylight_cycle_lighting_start_o,
   input wire logic daylight_cycle_lighting_stop_o,
   input wire logic lamp_cmd_valid_o,
   input wire iem_pkg::iem_lamp_op_t lamp_op_o,
   input wire logic [7:0] lamp_arg_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack missing one cycle after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   seq_start_run_a: assert property (seq_start_o |-> seq_run_o)
      else $error("sequence start without run");
   run_rise_cause_a: assert property ($rose(seq_run_o) |-> seq_start_o)
      else $error("sequence run rose without start");
   abort_halts_a: assert property (seq_abort_o |-> !seq_run_o)
      else $error("abort while still running");
   run_fall_cause_a: assert property ($fell(seq_run_o) |-> seq_abort_o || $past(seq_loop_done_i))
      else $error("sequence halted outside loop end or abort");
   dcl_start_a: assert property (daylight_cycle_lighting_start_o |->
      daylight_cycle_lighting_run_o && !daylight_cycle_lighting_stop_o)
      else $error("daylight start without run");
   dcl_stop_a: assert property (daylight_cycle_lighting_stop_o |->
      !daylight_cycle_lighting_run_o)
      else $error("daylight stop with run still high");
   comb_cause_a: assert property (comb_start_o |-> $past(short_push_i || double_push_i))
      else $error("combination start without push");
   level_range_a: assert property (lamp_cmd_valid_o && lamp_op_o == OP_LEVEL |->
      lamp_arg_o <= 8'h64)
      else $error("lamp level above full scale");
   scene_range_a: assert property (lamp_cmd_valid_o && lamp_op_o == OP_SCENE |->
      lamp_arg_o <= 8'h0F)
      else $error("scene number out of range");
   lamp_cause_a: assert property (lamp_cmd_valid_o && lamp_op_o != OP_OFF |->
      $past(occupied_i || vacant_i))
      else $error("lamp command without presence event");
endmodule
bind iem_mapper iem_mapper_checker #(.SEC_CYCLES(SEC_CYCLES)) iem_mapper_checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .short_push_i(short_push_i), .double_push_i(double_push_i),
   .occupied_i(occupied_i), .vacant_i(vacant_i), .seq_loop_done_i(seq_loop_done_i),
   .seq_run_o(seq_run_o), .seq_start_o(seq_start_o), .seq_abort_o(seq_abort_o),
   .comb_start_o(comb_start_o), .daylight_cycle_lighting_run_o(daylight_cycle_lighting_run_o),
   .daylight_cycle_lighting_start_o(daylight_cycle_lighting_start_o),
   .daylight_cycle_lighting_stop_o(daylight_cycle_lighting_stop_o),
   .lamp_cmd_valid_o(lamp_cmd_valid_o), .lamp_op_o(lamp_op_o), .lamp_arg_o(lamp_arg_o));

// >>> test/iem_seq_partner.sv
// Behavioural sequence engine: signals the end of each loop while running.
// Assumes the mapper's registered run level on the same clock.
`timescale 1ns/10ps
module iem_seq_partner #(
   parameter int unsigned LOOP_CYC = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic loop_done_o
);
   logic [7:0] cnt_r;
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_r <= 8'h00;
         loop_done_o <= 1'b0;
      end else begin
         loop_done_o <= (cnt_r == 8'(LOOP_CYC - 1));
         cnt_r <= (cnt_r == 8'(LOOP_CYC - 1)) ? 8'h00 : cnt_r + 8'h01;
      end
   end
endmodule

// >>> test/input_event_action_mapper_tb_top.sv
// Self-checking bench: register access over Wishbone plus classified events.
// Assumes a short seconds tick so timers expire within a few dozen cycles.
`timescale 1ns/10ps
module input_event_action_mapper_tb_top;
   import iem_pkg::*;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00, src_i = 8'h00, lamp_arg_o;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic short_push_i = 0, double_push_i = 0, occupied_i = 0, vacant_i = 0, seq_loop_done_i;
   logic seq_run_o, seq_start_o, seq_abort_o, relay_o, comb_start_o, lamp_cmd_valid_o;
   logic dcl_run, dcl_start, dcl_stop;
   iem_lamp_op_t lamp_op_o;
   int err_total = 0, n_tests = 0, n;
   logic [31:0] rc[5] = '{1, 2, 3, 3, 3};
   logic [7:0] rs[5] = '{5, 5, 5, 5, 6};
   logic re[5] = '{1, 0, 1, 0, 0};
   logic [2:0] la[4] = '{2, 3, 4, 1};
   iem_lamp_op_t lo[4] = '{OP_LEVEL, OP_LAST, OP_SCENE, OP_OFF};
   logic [7:0] lg[4] = '{8'h32, 8'h00, 8'h09, 8'h09};
   always #20 clk_i = ~clk_i;
   iem_mapper #(.SEC_CYCLES(10)) iem_mapper_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .short_push_i(short_push_i), .double_push_i(double_push_i), .occupied_i(occupied_i),
      .vacant_i(vacant_i), .src_i(src_i), .seq_loop_done_i(seq_loop_done_i),
      .seq_run_o(seq_run_o), .seq_start_o(seq_start_o), .seq_abort_o(seq_abort_o),
      .relay_o(relay_o), .comb_start_o(comb_start_o),
      .daylight_cycle_lighting_run_o(dcl_run), .daylight_cycle_lighting_start_o(dcl_start),
      .daylight_cycle_lighting_stop_o(dcl_stop), .lamp_cmd_valid_o(lamp_cmd_valid_o),
      .lamp_op_o(lamp_op_o), .lamp_arg_o(lamp_arg_o));
   iem_seq_partner #(.LOOP_CYC(8)) iem_seq_partner_inst (.clk_i(clk_i), .rst_i(rst_i),
      .run_i(seq_run_o), .loop_done_o(seq_loop_done_i));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // Kinds: 0 short, 1 double, 2 occupied, 3 vacant; one-cycle pulse
   task automatic ev(input int k, input logic [7:0] s);
      @(posedge clk_i);
      short_push_i <= (k == 0);
      double_push_i <= (k == 1);
      occupied_i <= (k == 2);
      vacant_i <= (k == 3);
      src_i <= s;
      @(posedge clk_i);
      {short_push_i, double_push_i, occupied_i, vacant_i} <= 4'h0;
      #1;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, OFS_SEQ_CFG, 0);
      chk(q, RST_SEQ_CFG);
      wb(0, 8'h40, 0);
      chk(q, 0);
      wb(1, OFS_SRC_SEL, 5);
      for (int i = 0; i < 5; i++) begin
         wb(1, OFS_BTN_CFG, rc[i]);
         ev(1, rs[i]);
         chk(relay_o, re[i]);
      end
      wb(1, OFS_SEQ_CFG, 32'h2);
      wb(1, OFS_BTN_CFG, 32'h964);
      ev(0, 5);
      chk({seq_start_o, seq_run_o, comb_start_o, dcl_start, dcl_run}, 5'h1F);
      n = 0;
      repeat (200) begin
         @(posedge clk_i);
         if (seq_loop_done_i) n++;
         if (!seq_run_o) break;
      end
      chk(n, 2);
      wb(0, OFS_STATUS, 0);
      chk(q[15:8], 2);
      ev(1, 5);
      chk({dcl_stop, dcl_run, comb_start_o}, 3'h4);
      ev(0, 5);
      ev(1, 5);
      chk({seq_abort_o, seq_run_o}, 2'h2);
      wb(1, OFS_SEQ_CFG, 32'h300);
      wb(1, OFS_BTN_CFG, 32'h3C);
      ev(0, 5);
      repeat (30) @(posedge clk_i);
      chk(seq_run_o, 1);
      ev(1, 5);
      chk({seq_abort_o, seq_run_o}, 2'h1);
      repeat (12) @(posedge clk_i);
      chk(seq_run_o, 0);
      for (int i = 0; i < 4; i++) begin
         wb(1, OFS_OCC_CFG, {8'h00, 8'h32, 8'h09, 5'h00, la[i]});
         ev(2, 5);
         chk({lamp_cmd_valid_o, lamp_op_o}, {1'b1, lo[i]});
         if (i != 1) chk(lamp_arg_o, lg[i]);
      end
      wb(1, OFS_OCC_CFG, 0);
      ev(2, 5);
      chk(lamp_cmd_valid_o, 0);
      wb(1, OFS_OCC_HLD, 2);
      wb(1, OFS_OCC_CFG, 32'h0500_0000);
      ev(2, 5);
      chk(relay_o, 1);
      repeat (8) @(posedge clk_i);
      ev(2, 5);
      repeat (10) @(posedge clk_i);
      chk(relay_o, 1);
      repeat (25) @(posedge clk_i);
      chk(relay_o, 0);
      wb(1, OFS_OCC_CFG, 32'h0100_0000);
      ev(2, 5);
      repeat (25) @(posedge clk_i);
      chk(relay_o, 1);
      wb(1, OFS_OCC_CFG, 32'h2000_0010);
      wb(1, OFS_VAC_DLY, 3);
      ev(3, 5);
      chk({relay_o, lamp_cmd_valid_o}, 2'h0);
      n = 0;
      repeat (40) begin
         @(posedge clk_i);
         n++;
         if (lamp_cmd_valid_o) break;
      end
      chk({n >= 18 && n <= 31, lamp_op_o}, {1'b1, OP_OFF});
      wb(1, OFS_OCC_CFG, 32'h0032_0020);
      ev(3, 5);
      chk({lamp_cmd_valid_o, lamp_op_o, lamp_arg_o}, {1'b1, OP_LEVEL, 8'h32});
      print_verdict();
   end
endmodule
